// [src/fms_pkg.sv]
// Constants shared by the mode-switch and discovery block.
// Assumes a 32-bit AHB-Lite register bus and a 100 MHz clock.
package fms_pkg;
  // ==========================================================
  // Instruction codes
  localparam logic [7:0] OP_RST_EN = 8'h66;
  localparam logic [7:0] OP_RST = 8'h99;
  localparam logic [7:0] OP_WR_EN = 8'h06;
  localparam logic [7:0] OP_VOL_EN = 8'h50;
  localparam logic [7:0] OP_WR_SR1 = 8'h01;
  localparam logic [7:0] OP_ENTER_4B = 8'hB7;
  localparam logic [7:0] OP_EXIT_4B = 8'hE9;
  // ==========================================================
  // Lane codes of the control register
  localparam logic [1:0] LANE_1 = 2'h0;
  localparam logic [1:0] LANE_2 = 2'h1;
  localparam logic [1:0] LANE_4 = 2'h2;
  localparam logic [1:0] LANE_BAD = 2'h3;
  // ==========================================================
  // Register byte addresses and parameter indices
  localparam logic [11:0] CTRL_ADDR = 12'h000;
  localparam logic [11:0] STATUS_ADDR = 12'h004;
  localparam logic [11:0] NVSR_ADDR = 12'h008;
  localparam logic [7:0] IDX_QUAD_SEQ = 8'h68;
  localparam logic [7:0] IDX_CONT_EXIT = 8'h69;
  localparam logic [7:0] IDX_CONT_ENTRY = 8'h6A;
  localparam logic [7:0] IDX_RSVD = 8'h6B;
  localparam logic [7:0] IDX_SR_WRITE = 8'h6C;
  localparam logic [7:0] IDX_SOFT_RST = 8'h6D;
  localparam logic [7:0] IDX_WIDE_EXIT = 8'h6E;
  localparam logic [7:0] IDX_WIDE_ENTRY = 8'h6F;
  // ==========================================================
  // Parameter byte values
  localparam logic [7:0] VAL_QUAD_SEQ = 8'h00;
  localparam logic [7:0] VAL_CONT_EXIT = 8'h90;
  localparam logic [7:0] VAL_CONT_ENTRY = 8'h48;
  localparam logic [7:0] VAL_RSVD = 8'hFF;
  localparam logic [7:0] VAL_SR_WRITE = 8'hE8;
  localparam logic [7:0] VAL_SOFT_RST = 8'h50;
  localparam logic [7:0] VAL_WIDE_EXIT = 8'hC1;
  localparam logic [7:0] VAL_WIDE_ENTRY = 8'hA5;
  localparam logic [7:0] SR_WRITE_RO_MASK = 8'hE0;
  localparam int QE_FIELD_LSB = 4;
  localparam logic [2:0] QE_NONE = 3'h0;
  localparam int QE_BIT = 6;
  // ==========================================================
  // Reset values and status bit positions
  localparam logic [7:0] NV_SR1_RST = 8'h00;
  localparam int ST_WEL = 8;
  localparam int ST_VOL_EN = 9;
  localparam int ST_VOL_ACT = 10;
  localparam int ST_ADDR4 = 11;
  localparam int ST_ARMED = 12;
  localparam int ST_QUAD = 13;
endpackage

// [src/fms_cmd_if.sv]
// Carries one received instruction frame from the pin receiver to the core.
// Assumes both ends run on the same system clock.
`timescale 1ns/1ns
interface fms_cmd_if;
  logic [7:0] instr;
  logic [7:0] data;
  logic has_data;
  logic valid;
  logic [1:0] lanes;
  modport rx (output instr, output data, output has_data, output valid, input lanes);
  modport core (input instr, input data, input has_data, input valid, output lanes);
endinterface

// [src/fms_sync.sv]
// Two-flop synchroniser for a group of pin levels.
// Assumes the inputs are levels from outside the clock domain.
`timescale 1ns/1ns
module fms_sync #(
  parameter int W = 1, // Number of bits.
  parameter logic [W-1:0] RST_VAL = '0 // Value held during reset.
) (
  input wire logic clock, // System clock.
  input wire logic sys_rst, // Synchronous reset, active high.
  input wire logic [W-1:0] d, // Asynchronous levels.
  output logic [W-1:0] q // Synchronised levels.
);
  logic [W-1:0] meta_reg;
  logic [W-1:0] q_reg;
  if (W < 1) begin : g_chk
    $error("fms_sync needs W of at least 1.");
  end
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      meta_reg <= RST_VAL;
      q_reg <= RST_VAL;
    end else begin
      meta_reg <= d;
      q_reg <= meta_reg;
    end
  end
  assign q = q_reg;
endmodule

// [src/fms_cmd_rx.sv]
// Deserialises instruction frames from synchronised serial pins.
// Assumes pins already pass a two-flop synchroniser; sclk is slow.
`timescale 1ns/1ns
module fms_cmd_rx (
  input wire logic clock, // System clock.
  input wire logic sys_rst, // Synchronous reset, active high.
  input wire logic sclk_s, // Synchronised serial clock.
  input wire logic cs_n_s, // Synchronised chip select, active low.
  input wire logic [3:0] dq_s, // Synchronised data lanes.
  fms_cmd_if.rx cmd // Frame output to the core.
);
  logic sclk_d_reg, sclk_d_next, cs_d_reg, cs_d_next;
  logic [7:0] sh_reg, sh_next, instr_reg, instr_next, data_reg, data_next;
  logic [3:0] bits_reg, bits_next, step;
  logic [1:0] nb_reg, nb_next;
  logic has_reg, has_next, valid_reg, valid_next;
  always_comb begin
    sclk_d_next = sclk_s;
    cs_d_next = cs_n_s;
    sh_next = sh_reg;
    bits_next = bits_reg;
    nb_next = nb_reg;
    instr_next = instr_reg;
    data_next = data_reg;
    has_next = has_reg;
    valid_next = 1'b0;
    step = 4'h1;
    if (cs_n_s) begin
      bits_next = 4'h0;
      // A frame ends on the rising select; empty frames are dropped.
      if (!cs_d_reg) begin
        valid_next = (nb_reg != 2'h0);
      end
    end else if (cs_d_reg) begin
      nb_next = 2'h0;
      has_next = 1'b0;
    end else if (sclk_s && !sclk_d_reg) begin
      // Bits arrive on one, two or four lanes as the mode says.
      unique case (cmd.lanes)
        fms_pkg::LANE_2: begin
          sh_next = {sh_reg[5:0], dq_s[1:0]};
          step = 4'h2;
        end
        fms_pkg::LANE_4: begin
          sh_next = {sh_reg[3:0], dq_s};
          step = 4'h4;
        end
        default: sh_next = {sh_reg[6:0], dq_s[0]};
      endcase
      bits_next = bits_reg + step;
      if (bits_next == 4'h8) begin
        bits_next = 4'h0;
        if (nb_reg == 2'h0) begin
          instr_next = sh_next;
        end else if (nb_reg == 2'h1) begin
          data_next = sh_next;
          has_next = 1'b1;
        end
        if (nb_reg != 2'h2) begin
          nb_next = nb_reg + 2'h1;
        end
      end
    end
  end
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      sclk_d_reg <= 1'b1;
      cs_d_reg <= 1'b1;
      sh_reg <= 8'h00;
      bits_reg <= 4'h0;
      nb_reg <= 2'h0;
      instr_reg <= 8'h00;
      data_reg <= 8'h00;
      has_reg <= 1'b0;
      valid_reg <= 1'b0;
    end else begin
      sclk_d_reg <= sclk_d_next;
      cs_d_reg <= cs_d_next;
      sh_reg <= sh_next;
      bits_reg <= bits_next;
      nb_reg <= nb_next;
      instr_reg <= instr_next;
      data_reg <= data_next;
      has_reg <= has_next;
      valid_reg <= valid_next;
    end
  end
  assign cmd.instr = instr_reg;
  assign cmd.data = data_reg;
  assign cmd.has_data = has_reg;
  assign cmd.valid = valid_reg;
endmodule

// [src/fms_top.sv]
// Mode-switch instruction interpreter with its discovery parameter bytes.
// Assumes a single AHB-Lite master and a serial host on the pins.
//
// Summary of operation
// - Reset needs 66h then 99h as separate frames, on the current lane count.
// - Instruction E9h leaves 4-byte addressing for 3-byte addressing.
// - Leaving 4-byte addressing does not need the write-enable latch.
// - At power-up status register 1 shows its non-volatile copy.
// - Write-enable 06h before a status write updates the non-volatile copy.
// - Instruction 50h arms a volatile write that then overrides until power-off.
// - After power-up the volatile copy may be activated to override.
// - Quad-enable code 000b means no bit; 010b means status bit 6. The parameter byte advertises 100b, and any nonzero code selects bit 6.
// - The quad-mode disable-sequence field reads 0000b.
// - Parameter bit 09 reads 0: continuous quad read unsupported.
// - A read-only status register reports zeros in bits 4:0 of its field.
`timescale 1ns/1ns
module fms_top #(
  parameter logic [7:0] NV_SR1_INIT = fms_pkg::NV_SR1_RST, // Stored copy at power-up.
  parameter bit SR1_READ_ONLY = 1'b0 // Status register 1 is read-only.
) (
  input wire logic clock, // System clock, 100 MHz.
  input wire logic sys_rst, // Synchronous reset, active high.
  input wire logic hsel, // AHB slave select.
  input wire logic [31:0] haddr, // AHB address.
  input wire logic [1:0] htrans, // AHB transfer type.
  input wire logic hwrite, // AHB write.
  input wire logic [2:0] hsize, // AHB size, word only.
  input wire logic [31:0] hwdata, // AHB write data.
  input wire logic hready, // AHB bus ready.
  output logic [31:0] hrdata, // AHB read data.
  output logic hreadyout, // AHB slave ready.
  output logic hresp, // AHB response, always OKAY.
  input wire logic spi_sclk, // Serial clock pin.
  input wire logic spi_cs_n, // Chip select pin, active low.
  input wire logic [3:0] spi_dq_in, // Data pin levels.
  output logic [7:0] sr1_out, // Active status register 1.
  output logic quad_en_out, // Quad operation enabled.
  output logic addr4_out // 4-byte addressing active.
);
  // ==========================================================
  // Pin synchronisers and frame receiver
  logic [5:0] pins_s;
  fms_cmd_if cmd_bus ();

  fms_sync #(
    .W(6),
    .RST_VAL(6'h30)
  ) u_sync (
    .clock(clock),
    .sys_rst(sys_rst),
    .d({spi_sclk, spi_cs_n, spi_dq_in}),
    .q(pins_s)
  );

  fms_cmd_rx u_rx (
    .clock(clock),
    .sys_rst(sys_rst),
    .sclk_s(pins_s[5]),
    .cs_n_s(pins_s[4]),
    .dq_s(pins_s[3:0]),
    .cmd(cmd_bus.rx)
  );

  // ==========================================================
  // Instruction state
  logic [1:0] lanes_reg, lanes_next;
  logic wel_reg, wel_next, vol_en_reg, vol_en_next;
  logic vol_act_reg, vol_act_next, addr4_reg, addr4_next;
  logic armed_reg, armed_next;
  logic [7:0] nv_sr1_reg, nv_sr1_next, vol_sr1_reg, vol_sr1_next;
  logic [7:0] sr1_eff, sr1_out_reg;
  logic [2:0] qe_code;
  logic quad_en, quad_en_reg;
  // AHB state.
  logic wr_pend_reg, wr_pend_next, addr_ph;
  logic [11:0] wr_addr_reg, wr_addr_next;
  logic [31:0] hrdata_reg, hrdata_next, rd_word;
  logic [7:0] pidx;

  assign cmd_bus.lanes = lanes_reg;

  // The volatile copy overrides once it is active.
  assign sr1_eff = vol_act_reg ? vol_sr1_reg : nv_sr1_reg;

  // Quad enable follows the code advertised in the parameter byte.
  assign qe_code = fms_pkg::VAL_CONT_ENTRY[fms_pkg::QE_FIELD_LSB +: 3];
  assign quad_en = (qe_code == fms_pkg::QE_NONE) ? 1'b1 : sr1_eff[fms_pkg::QE_BIT];

  function automatic logic [7:0] param_byte(input logic [7:0] idx);
    logic [7:0] v;
    v = 8'h00;
    case (idx)
      fms_pkg::IDX_QUAD_SEQ: v = fms_pkg::VAL_QUAD_SEQ;
      fms_pkg::IDX_CONT_EXIT: v = fms_pkg::VAL_CONT_EXIT;
      fms_pkg::IDX_CONT_ENTRY: v = fms_pkg::VAL_CONT_ENTRY;
      fms_pkg::IDX_RSVD: v = fms_pkg::VAL_RSVD;
      fms_pkg::IDX_SR_WRITE: begin
        v = fms_pkg::VAL_SR_WRITE;
        if (SR1_READ_ONLY) begin
          v = v & fms_pkg::SR_WRITE_RO_MASK;
        end
      end
      fms_pkg::IDX_SOFT_RST: v = fms_pkg::VAL_SOFT_RST;
      fms_pkg::IDX_WIDE_EXIT: v = fms_pkg::VAL_WIDE_EXIT;
      fms_pkg::IDX_WIDE_ENTRY: v = fms_pkg::VAL_WIDE_ENTRY;
      default: v = 8'h00;
    endcase
    return v;
  endfunction

  always_comb begin
    lanes_next = lanes_reg;
    wel_next = wel_reg;
    vol_en_next = vol_en_reg;
    vol_act_next = vol_act_reg;
    addr4_next = addr4_reg;
    armed_next = armed_reg;
    nv_sr1_next = nv_sr1_reg;
    vol_sr1_next = vol_sr1_reg;
    if (wr_pend_reg && wr_addr_reg == fms_pkg::CTRL_ADDR &&
        hwdata[1:0] != fms_pkg::LANE_BAD) begin
      lanes_next = hwdata[1:0];
    end
    if (cmd_bus.valid) begin
      // Any frame other than the enable itself disarms the reset pair.
      armed_next = 1'b0;
      case (cmd_bus.instr)
        fms_pkg::OP_RST_EN: armed_next = 1'b1;
        fms_pkg::OP_RST: begin
          if (armed_reg) begin
            // Soft reset; the volatile copy stays until power-off.
            wel_next = 1'b0;
            vol_en_next = 1'b0;
            addr4_next = 1'b0;
          end
        end
        fms_pkg::OP_WR_EN: wel_next = 1'b1;
        fms_pkg::OP_VOL_EN: vol_en_next = 1'b1;
        fms_pkg::OP_WR_SR1: begin
          if (cmd_bus.has_data && !SR1_READ_ONLY) begin
            if (wel_reg) begin
              nv_sr1_next = cmd_bus.data;
            end else if (vol_en_reg) begin
              vol_sr1_next = cmd_bus.data;
              vol_act_next = 1'b1;
            end
          end
          wel_next = 1'b0;
          vol_en_next = 1'b0;
        end
        fms_pkg::OP_ENTER_4B: addr4_next = 1'b1;
        fms_pkg::OP_EXIT_4B: addr4_next = 1'b0;
        default: armed_next = 1'b0;
      endcase
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      lanes_reg <= fms_pkg::LANE_1;
      wel_reg <= 1'b0;
      vol_en_reg <= 1'b0;
      vol_act_reg <= 1'b0;
      addr4_reg <= 1'b0;
      armed_reg <= 1'b0;
      nv_sr1_reg <= NV_SR1_INIT;
      vol_sr1_reg <= 8'h00;
      sr1_out_reg <= NV_SR1_INIT;
      quad_en_reg <= 1'b0;
    end else begin
      lanes_reg <= lanes_next;
      wel_reg <= wel_next;
      vol_en_reg <= vol_en_next;
      vol_act_reg <= vol_act_next;
      addr4_reg <= addr4_next;
      armed_reg <= armed_next;
      nv_sr1_reg <= nv_sr1_next;
      vol_sr1_reg <= vol_sr1_next;
      sr1_out_reg <= sr1_eff;
      quad_en_reg <= quad_en;
    end
  end

  // ==========================================================
  // AHB-Lite slave, zero wait states
  assign addr_ph = hsel && htrans[1] && hready;
  assign pidx = haddr[9:2];

  always_comb begin
    rd_word = 32'h0000_0000;
    if (haddr[11:0] == fms_pkg::CTRL_ADDR) begin
      rd_word[1:0] = lanes_reg;
    end else if (haddr[11:0] == fms_pkg::STATUS_ADDR) begin
      rd_word[7:0] = sr1_eff;
      rd_word[fms_pkg::ST_WEL] = wel_reg;
      rd_word[fms_pkg::ST_VOL_EN] = vol_en_reg;
      rd_word[fms_pkg::ST_VOL_ACT] = vol_act_reg;
      rd_word[fms_pkg::ST_ADDR4] = addr4_reg;
      rd_word[fms_pkg::ST_ARMED] = armed_reg;
      rd_word[fms_pkg::ST_QUAD] = quad_en;
    end else if (haddr[11:0] == fms_pkg::NVSR_ADDR) begin
      rd_word[7:0] = nv_sr1_reg;
    end else if (haddr[11:10] == 2'h0 && haddr[1:0] == 2'h0) begin
      rd_word[7:0] = param_byte(pidx);
    end
  end

  always_comb begin
    wr_pend_next = addr_ph && hwrite;
    wr_addr_next = haddr[11:0];
    hrdata_next = hrdata_reg;
    if (addr_ph && !hwrite) begin
      hrdata_next = rd_word;
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      wr_pend_reg <= 1'b0;
      wr_addr_reg <= 12'h000;
      hrdata_reg <= 32'h0000_0000;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else begin
      wr_pend_reg <= wr_pend_next;
      wr_addr_reg <= wr_addr_next;
      hrdata_reg <= hrdata_next;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
  end

  assign hrdata = hrdata_reg;
  assign sr1_out = sr1_out_reg;
  assign quad_en_out = quad_en_reg;
  assign addr4_out = addr4_reg;

  // ==========================================================
  // Assertions
  sequence seq_cmd(logic [7:0] op);
    cmd_bus.valid && cmd_bus.instr == op;
  endsequence

  sequence seq_rd(logic [7:0] idx);
    addr_ph && !hwrite && haddr[11:0] == {2'h0, idx, 2'h0};
  endsequence

  sequence seq_soft_rst;
    seq_cmd(fms_pkg::OP_RST) ##0 armed_reg;
  endsequence

  reset_arm_a: assert property (@(posedge clock) disable iff (sys_rst)
    seq_cmd(fms_pkg::OP_RST_EN) |=> armed_reg)
    else $error("Reset enable did not arm the reset pair.");

  reset_disarm_a: assert property (@(posedge clock) disable iff (sys_rst)
    cmd_bus.valid && cmd_bus.instr != fms_pkg::OP_RST_EN |=> !armed_reg)
    else $error("A frame other than reset enable left the pair armed.");

  reset_pair_a: assert property (@(posedge clock) disable iff (sys_rst)
    seq_soft_rst |=> !addr4_reg && !wel_reg && !vol_en_reg && !armed_reg)
    else $error("Reset pair did not reset the mode state.");

  reset_keep_vol_a: assert property (@(posedge clock) disable iff (sys_rst)
    seq_soft_rst |=> $stable(vol_act_reg) && $stable(vol_sr1_reg))
    else $error("Soft reset disturbed the volatile copy.");

  exit_wide_a: assert property (@(posedge clock) disable iff (sys_rst)
    seq_cmd(fms_pkg::OP_EXIT_4B) |=> !addr4_out)
    else $error("Exit of 4-byte addressing failed.");

  enter_wide_a: assert property (@(posedge clock) disable iff (sys_rst)
    seq_cmd(fms_pkg::OP_ENTER_4B) |=> addr4_out)
    else $error("Entry to 4-byte addressing failed.");

  exit_no_wel_a: assert property (@(posedge clock) disable iff (sys_rst)
    seq_cmd(fms_pkg::OP_EXIT_4B) ##0 (addr4_reg && !wel_reg) |=> $fell(addr4_reg))
    else $error("Exit of 4-byte addressing waited for write enable.");

  powerup_load_a: assert property (@(posedge clock) disable iff (sys_rst)
    $past(sys_rst) |-> sr1_eff == NV_SR1_INIT && !vol_act_reg ##1 sr1_out == NV_SR1_INIT)
    else $error("Status register 1 did not load the stored copy.");

  nv_write_a: assert property (@(posedge clock) disable iff (sys_rst)
    seq_cmd(fms_pkg::OP_WR_SR1) ##0 (cmd_bus.has_data && wel_reg && !SR1_READ_ONLY)
    |=> nv_sr1_reg == $past(cmd_bus.data) && !wel_reg)
    else $error("Enabled status write missed the stored copy.");

  wel_set_a: assert property (@(posedge clock) disable iff (sys_rst)
    seq_cmd(fms_pkg::OP_WR_EN) |=> wel_reg)
    else $error("Write enable did not set the latch.");

  nv_guard_a: assert property (@(posedge clock) disable iff (sys_rst)
    !(cmd_bus.valid && cmd_bus.instr == fms_pkg::OP_WR_SR1 && wel_reg) |=> $stable(nv_sr1_reg))
    else $error("Stored copy changed without an enabled status write.");

  sr_write_clear_a: assert property (@(posedge clock) disable iff (sys_rst)
    seq_cmd(fms_pkg::OP_WR_SR1) |=> !wel_reg && !vol_en_reg)
    else $error("Status write left a write enable standing.");

  vol_write_a: assert property (@(posedge clock) disable iff (sys_rst)
    seq_cmd(fms_pkg::OP_WR_SR1) ##0 (cmd_bus.has_data && vol_en_reg && !wel_reg
    && !SR1_READ_ONLY) |=> vol_act_reg ##1 sr1_out == $past(cmd_bus.data, 2))
    else $error("Volatile status write did not take over.");

  vol_arm_a: assert property (@(posedge clock) disable iff (sys_rst)
    seq_cmd(fms_pkg::OP_VOL_EN) |=> vol_en_reg)
    else $error("Volatile write enable did not arm.");

  vol_hold_a: assert property (@(posedge clock) disable iff (sys_rst)
    vol_act_reg |=> vol_act_reg && sr1_eff == vol_sr1_reg)
    else $error("Volatile copy lost its override before power-off.");

  quad_bit_a: assert property (@(posedge clock) disable iff (sys_rst)
    qe_code != fms_pkg::QE_NONE && $changed(sr1_eff[fms_pkg::QE_BIT])
    |=> quad_en_out == $past(sr1_eff[fms_pkg::QE_BIT]))
    else $error("Quad enable does not follow status bit 6.");

  quad_exit_a: assert property (@(posedge clock) disable iff (sys_rst)
    seq_rd(fms_pkg::IDX_QUAD_SEQ) |=> hrdata[3:0] == 4'h0 && hrdata[31:8] == 24'h0)
    else $error("Quad disable-sequence field not zero.");

  no_cont_read_a: assert property (@(posedge clock) disable iff (sys_rst)
    seq_rd(fms_pkg::IDX_CONT_EXIT) |=> !hrdata[1] && hrdata[7:0] == fms_pkg::VAL_CONT_EXIT)
    else $error("Continuous quad read advertised.");

  ro_field_a: assert property (@(posedge clock) disable iff (sys_rst)
    seq_rd(fms_pkg::IDX_SR_WRITE) ##0 SR1_READ_ONLY |=> hrdata[4:0] == 5'h00)
    else $error("Read-only status field shows write methods.");

  ro_keep_a: assert property (@(posedge clock) disable iff (sys_rst)
    SR1_READ_ONLY |=> $stable(nv_sr1_reg) && !vol_act_reg)
    else $error("Read-only status register was written.");

  bus_okay_a: assert property (@(posedge clock) disable iff (sys_rst)
    addr_ph |=> hreadyout && !hresp)
    else $error("Bus transfer not answered ready and OKAY.");

  lane_bad_a: assert property (@(posedge clock) disable iff (sys_rst)
    wr_pend_reg && wr_addr_reg == fms_pkg::CTRL_ADDR && hwdata[1:0] == fms_pkg::LANE_BAD
    |=> $stable(lanes_reg))
    else $error("Unsupported lane code was accepted.");
endmodule

// [bench/fms_host_model.sv]
// Behavioural serial host that sends instruction frames to the mode-switch block.
// Assumes it shares the system clock with the block and that the bench picks the lane count.
`timescale 1ns/1ns
module fms_host_model (
  input wire logic clock, // System clock.
  output logic spi_sclk, // Serial clock, still outside frames.
  output logic spi_cs_n, // Chip select, active low.
  output logic [3:0] spi_dq // Data lanes.
);
  initial begin
    spi_sclk = 1'b0;
    spi_cs_n = 1'b1;
    spi_dq = 4'h0;
  end
  // ==========================================================
  // Frame sender
  // Idle lanes toggle so that no stale level can pass for data.
  task automatic send(input int nl, input logic [15:0] bits, input int nb);
    logic [15:0] sh;
    sh = bits;
    @(posedge clock);
    spi_cs_n <= 1'b0;
    for (int i = 0; i < nb; i += nl) begin
      repeat (4) @(posedge clock);
      case (nl)
        1: spi_dq <= {~spi_dq[3:1], sh[15]};
        2: spi_dq <= {~spi_dq[3:2], sh[15:14]};
        default: spi_dq <= sh[15:12];
      endcase
      sh = sh << nl;
      repeat (4) @(posedge clock);
      spi_sclk <= 1'b1;
      repeat (4) @(posedge clock);
      spi_sclk <= 1'b0;
    end
    repeat (4) @(posedge clock);
    spi_cs_n <= 1'b1;
    spi_dq <= ~spi_dq;
    repeat (10) @(posedge clock);
  endtask
  // ==========================================================
  // Instruction helpers
  // The host never enters the continuous quad read mode, so no quad enable is needed.
  task automatic op(input int nl, input logic [7:0] code);
    send(nl, {code, 8'h00}, 8);
  endtask
  task automatic op2(input int nl, input logic [7:0] code, input logic [7:0] d);
    send(nl, {code, d}, 16);
  endtask
  task automatic soft_reset(input int nl);
    op(nl, fms_pkg::OP_RST_EN);
    op(nl, fms_pkg::OP_RST);
  endtask
  task automatic wr_nv(input int nl, input logic [7:0] d);
    op(nl, fms_pkg::OP_WR_EN);
    op2(nl, fms_pkg::OP_WR_SR1, d);
  endtask
endmodule

// [bench/test_flash_mode_switch_and_discovery.sv]
// Self-checking bench for the mode-switch block: registers over AHB-Lite, frames from a host model.
// Assumes the block answers every bus transfer with OKAY and ties hready to hreadyout.
`timescale 1ns/1ns
module test_flash_mode_switch_and_discovery;
  localparam logic [7:0] PEXP [8] = '{8'h00, 8'h90, 8'h48, 8'hFF, 8'hE8, 8'h50, 8'hC1, 8'hA5};
  logic clock, sys_rst, hsel, hwrite, hresp, hreadyout, quad_en_out, addr4_out;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [31:0] haddr, hwdata, hrdata, hrdata_ro;
  logic spi_sclk, spi_cs_n;
  logic [3:0] spi_dq;
  logic [7:0] sr1_out, sr1_ro, d, v, nv;
  wire hready = hreadyout;
  int n_fail = 0;
  int n_tests = 0;
  fms_top #(.NV_SR1_INIT(fms_pkg::NV_SR1_RST), .SR1_READ_ONLY(1'b0)) dut_u (
    .clock(clock), .sys_rst(sys_rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .spi_sclk(spi_sclk), .spi_cs_n(spi_cs_n),
    .spi_dq_in(spi_dq), .sr1_out(sr1_out), .quad_en_out(quad_en_out), .addr4_out(addr4_out)
  );
  // A read-only twin sees the same bus and frames.
  fms_top #(.NV_SR1_INIT(fms_pkg::NV_SR1_RST), .SR1_READ_ONLY(1'b1)) dut_ro_u (
    .clock(clock), .sys_rst(sys_rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata_ro),
    .hreadyout(), .hresp(), .spi_sclk(spi_sclk), .spi_cs_n(spi_cs_n),
    .spi_dq_in(spi_dq), .sr1_out(sr1_ro), .quad_en_out(), .addr4_out()
  );
  fms_host_model host_u (.clock(clock), .spi_sclk(spi_sclk), .spi_cs_n(spi_cs_n), .spi_dq(spi_dq));
  always #5 clock = ~clock;
  // ==========================================================
  // Checking and bus tasks
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_fail++;
      $display("Error at %0t: saw %h, expected %h", $time, got, exp);
    end
  endtask
  task automatic ahb(input logic w, input logic [31:0] a, input logic [31:0] wd,
                     output logic [31:0] rd);
    @(posedge clock);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= w;
    htrans <= 2'h2;
    do @(posedge clock); while (hready !== 1'b1);
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge clock); while (hready !== 1'b1);
    rd = hrdata;
  endtask
  task automatic wr(input logic [31:0] a, input logic [31:0] wd);
    logic [31:0] rd;
    ahb(1'b1, a, wd, rd);
  endtask
  task automatic rdchk(input logic [31:0] a, input logic [31:0] exp);
    logic [31:0] rd;
    ahb(1'b0, a, 32'h0, rd);
    check(rd, exp);
    check(32'(hresp), 32'h0);
  endtask
  // Bits carried per serial edge for a lane code.
  function automatic int nl(input int code);
    return 1 << code;
  endfunction
  task automatic stop_test();
    $display("Comparisons %0d, mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge clock);
    n_fail++;
    $display("Error at %0t: watchdog expired", $time);
    stop_test();
  end
  // ==========================================================
  // Main sequence
  initial begin
    clock = 1'b0;
    sys_rst = 1'b1;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    nv = fms_pkg::NV_SR1_RST;
    void'($urandom(19));
    repeat (8) @(posedge clock);
    sys_rst <= 1'b0;
    repeat (3) @(posedge clock);
    check(32'(sr1_out), 32'(nv));
    check(32'(addr4_out), 32'h0);
    rdchk(32'h008, 32'(nv));
    for (int i = 0; i < 8; i++) begin
      rdchk(32'h1A0 + 32'(4 * i), 32'(PEXP[i]));
    end
    rdchk(32'h1B0, 32'(PEXP[4]));
    check(hrdata_ro, {24'h0, PEXP[4][7:5], 5'h00});
    wr(32'h1A0, $urandom);
    rdchk(32'h1A0, 32'h0);
    rdchk(32'h1C0, 32'h0);
    host_u.op(1, fms_pkg::OP_ENTER_4B);
    check(32'(addr4_out), 32'h1);
    host_u.op(1, fms_pkg::OP_EXIT_4B);
    check(32'(addr4_out), 32'h0);
    for (int k = 0; k < 2; k++) begin
      d = 8'($urandom);
      d[6] = k[0];
      host_u.op2(1, fms_pkg::OP_WR_SR1, ~d);
      check(32'(sr1_out), 32'(nv));
      host_u.wr_nv(1, d);
      nv = d;
      rdchk(32'h008, 32'(d));
      check(32'(sr1_out), 32'(d));
      check(32'(quad_en_out), 32'(d[6]));
      check(32'(sr1_ro), 32'(fms_pkg::NV_SR1_RST));
    end
    v = 8'($urandom);
    host_u.op(1, fms_pkg::OP_VOL_EN);
    host_u.op2(1, fms_pkg::OP_WR_SR1, v);
    check(32'(sr1_out), 32'(v));
    rdchk(32'h008, 32'(nv));
    nv = ~v;
    host_u.wr_nv(1, nv);
    rdchk(32'h008, 32'(nv));
    check(32'(sr1_out), 32'(v));
    check(32'(quad_en_out), 32'(v[6]));
    for (int l = 0; l < 3; l++) begin
      wr(32'h000, 32'(l));
      rdchk(32'h000, 32'(l));
      host_u.op(nl(l), fms_pkg::OP_ENTER_4B);
      host_u.op(nl(l), fms_pkg::OP_RST_EN);
      host_u.op(nl(l), 8'hFF);
      host_u.op(nl(l), fms_pkg::OP_RST);
      check(32'(addr4_out), 32'h1);
      host_u.soft_reset(nl(l));
      check(32'(addr4_out), 32'h0);
      check(32'(sr1_out), 32'(v));
      rdchk(32'h004, {18'h0, v[6], 2'b00, 1'b1, 2'b00, v});
    end
    wr(32'h000, 32'h3);
    rdchk(32'h000, 32'h2);
    stop_test();
  end
endmodule
